// [byte_controller_core.sv]
/*
 byte_controller_core: 8-bit controller core executing bit and literal/control
 instructions, with apb access to program store, files and control.
 assumes pclk at 125 mhz, event and port inputs asynchronous to pclk.
 assumes an apb master that keeps the setup/access order, a program loaded
 while halted, and pull-ups on the i/o lines outside this block.
*/
`timescale 1ns/1ps
module byte_controller_core (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // general i/o lines, open-drain style
   input  wire logic [31:0] port_in,
   output logic      [31:0] port_out,
   output logic      [31:0] port_oe,
   // external event input for the counter
   input  wire logic        event_in
);
   // how the core is used:
   //  - halt, load program and files over apb,
   //    then set run
   //  - four pclk cycles per instruction; all
   //    results land on the last edge
   //  - a taken skip or a pc change adds four
   //    idle flush cycles
   //  - byte file opcodes run as no-ops
   //  - ports are open-drain: latch 0 pulls the
   //    line low, latch 1 releases it
   //  - file 1 counts rising event edges
   //  - pc starts at the top word, 0x1ff, so the
   //    last program word is the first executed
   //  - status keeps carry in bit 0 and nibble
   //    carry in bit 1; only zero is updated here

   // limitations:
   //  - apb file and program writes are dropped
   //    while running, so apb and execute never
   //    fight over a file
   //  - the stack is two deep: a third nested
   //    call loses the oldest entry
   //  - the pc file shows only pc[7:0]
   //  - event pulses need a few pclk cycles high
   //    and low to pass the synchroniser
   //  - storage is plain flops; stack_r[0] is
   //    the top of the return stack
   // storage
   logic [7:0]  file_r [core_pkg::FILE_N];
   logic [11:0] prog_r [core_pkg::PROG_N];
   logic [8:0]  stack_r [core_pkg::STACK_N];
   logic [7:0]  w_r;
   logic [8:0]  pc_r;
   logic [1:0]  phase_r;
   logic        skip_r;
   logic        run_r;
   logic [8:0]  paddr_r;
   logic [8:0]  pc_inc;
   logic        hop_r;
   core_pkg::state_e state_r;
   logic [31:0] pin_s1_r;
   logic [31:0] pin_s2_r;
   logic        ev_s1_r;
   logic        ev_s2_r;
   logic        ev_d_r;
   logic        ev_src_r;

   // for instructions file 0 is indirect: accesses go to the
   // file the pointer names, so a program can
   // walk a table by bumping the pointer
   // resolve indirect address through the pointer
   function automatic logic [4:0] resolve(input logic [4:0] f, input logic [7:0] ptr);
      resolve = (f == core_pkg::F_INDIRECT) ? ptr[4:0] : f;
   endfunction : resolve

   // a port reads pin level anded with latch,
   // so a latch bit of 0 always reads 0
   // the pointer reads ones in its top bits and
   // the pc file reads the live counter
   // file read view: pointer top bits, ports read pins, pc low byte
   function automatic logic [7:0] fread(input logic [4:0] a, input logic [7:0] fv,
                                        input logic [31:0] pins, input logic [8:0] pc);
      if (a == core_pkg::F_POINTER) begin
         fread = {3'b111, fv[4:0]};
      end else if (a == core_pkg::F_PC) begin
         fread = pc[7:0];
      end else if (a >= core_pkg::F_PORT_A && a <= core_pkg::F_PORT_D) begin
         fread = pins[8*(a-core_pkg::F_PORT_A) +: 8] & fv;
      end else begin
         fread = fv;
      end
   endfunction : fread

   // word layout, msb first:
   //   bit:     [11:8] op, [7:5] bit, [4:0] file
   //   literal: [11:8] op, [7:0] literal
   //   jump:    [11:9] op, [8] page, [7:0] target
   // decode is combinational from the store at
   // pc and settles long before phase 3; the
   // store must stay still while running
   // decode of current instruction
   logic [11:0]          insn;
   core_pkg::bit_insn_s  bi;
   logic [4:0]           fa;
   logic [7:0]           fval;
   logic [7:0]           lit;
   logic [7:0]           alu;
   logic                 bit_v;
   assign insn = prog_r[pc_r];
   assign bi   = insn;
   assign fa   = resolve(bi.file, file_r[core_pkg::F_POINTER]);
   assign fval = (fa == core_pkg::F_INDIRECT) ? 8'h00
                 : fread(fa, file_r[fa], pin_s2_r, pc_r);
   assign lit  = insn[7:0];
   assign bit_v = fval[bi.bitn];
   assign pc_inc = pc_r + 9'h001;

   // move falls to the default; the zero flag
   // is taken from this same result
   // literal logic unit
   always_comb begin
      case (insn[11:8])
         core_pkg::or_literal_op:  alu = w_r | lit;
         core_pkg::and_literal_op: alu = w_r & lit;
         core_pkg::xor_literal_op: alu = w_r ^ lit;
         default:                  alu = lit;
      endcase
   end

   // pins and event_in are asynchronous: two
   // flops before any logic. the software event
   // bit joins ahead of the first flop so both
   // sources share one edge detector. ev_d_r
   // resets low, the idle level, so reset never
   // looks like an event edge
   // synchronisers for pins and the event input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= 32'h0000_0000;
         pin_s2_r <= 32'h0000_0000;
         ev_s1_r  <= 1'b0;
         ev_s2_r  <= 1'b0;
         ev_d_r   <= 1'b0;
      end else begin
         pin_s1_r <= port_in;
         pin_s2_r <= pin_s1_r;
         ev_s1_r  <= event_in | ev_src_r;
         ev_s2_r  <= ev_s1_r;
         ev_d_r   <= ev_s2_r;
      end
   end

   // map, one aligned word each, low bits used:
   //   0x000 control: bit 0 run, bit 1 event
   //   0x004 status: pc [8:0], state [10:9]
   //   0x008 program address
   //   0x00c program word, write steps address
   //   0x010 working register, read only
   //   0x080 + 4*n file n, n from 0 to 31
   // other addresses answer with pslverr.
   // read data is latched in setup and pready
   // rises with it, so each transfer ends in
   // its first access cycle, where writes land
   // pslverr is a one-cycle pulse beside pready
   // apb: zero-wait slave, program and file loads only while halted
   logic        wr_en;
   logic [11:0] pa;
   assign wr_en = psel && penable && pwrite;
   assign pa    = paddr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r    <= 1'b0;
         ev_src_r <= 1'b0;
         paddr_r  <= 9'h000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         prdata   <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable) begin
            if (pa == core_pkg::A_CTRL) begin
               prdata <= {30'h0, ev_src_r, run_r};
            end else if (pa == core_pkg::A_STAT) begin
               prdata <= {21'h0, state_r, pc_r};
            end else if (pa == core_pkg::A_PADDR) begin
               prdata <= {23'h0, paddr_r};
            end else if (pa == core_pkg::A_PDATA) begin
               prdata <= {20'h0, prog_r[paddr_r]};
            end else if (pa == core_pkg::A_WREG) begin
               prdata <= {24'h0, w_r};
            end else if (pa[11:7] == core_pkg::A_FILE_BASE[11:7] && pa[1:0] == 2'b00) begin
               prdata <= {24'h0, fread(pa[6:2], file_r[pa[6:2]], pin_s2_r, pc_r)};
            end else begin
               pslverr <= 1'b1;
            end
         end
         if (wr_en && pready) begin
            if (pa == core_pkg::A_CTRL) begin
               run_r    <= pwdata[core_pkg::CTRL_RUN];
               ev_src_r <= pwdata[core_pkg::CTRL_EVENT];
            end else if (pa == core_pkg::A_PADDR) begin
               paddr_r  <= pwdata[8:0];
            end else if (pa == core_pkg::A_PDATA) begin
               paddr_r  <= paddr_r + 9'h001;
            end
         end
      end
   end

   // no reset: contents are what software
   // loads. a write while running is dropped
   // but the address still steps, so set the
   // address again after halting. reads do not
   // step the address
   // program store: loaded by software, auto-incrementing address
   always_ff @(posedge pclk) begin
      if (wr_en && pready && pa == core_pkg::A_PDATA && !run_r) begin
         prog_r[paddr_r] <= pwdata[11:0];
      end
   end

   // phase walk of one instruction in exec:
   //   phases 0 to 2: decode settles
   //   phase 3: results land at its end
   // after a taken skip or pc change, skip_r is
   // high in the next phase 0; flush covers
   // phases 1 to 3 and returns to exec, so the
   // pair costs eight cycles. clearing run drops
   // to halt, which restarts the phase count
   // phase_r wraps on purpose at the end of
   // every instruction
   // sequencer: four pclk phases per instruction; four more as a flush
   logic exec_now;
   assign exec_now = (state_r != core_pkg::st_halt) && (phase_r == core_pkg::PHASE_LAST);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= 2'h0;
         state_r <= core_pkg::st_halt;
      end else begin
         phase_r <= (state_r == core_pkg::st_halt) ? 2'h0 : phase_r + 2'h1;
         if (!run_r) begin
            state_r <= core_pkg::st_halt;
         end else begin
            case (state_r)
               core_pkg::st_halt:  state_r <= core_pkg::st_exec;
               core_pkg::st_exec:  state_r <= skip_r ? core_pkg::st_flush : core_pkg::st_exec;
               core_pkg::st_flush: state_r <= exec_now ? core_pkg::st_exec : core_pkg::st_flush;
               default:            state_r <= core_pkg::st_halt;
            endcase
         end
      end
   end

   // all program-visible state moves here.
   // hop_r marks a flush that belongs to a
   // taken skip; only then does the flush step
   // pc past the suppressed word. jumps, calls,
   // returns and pc writes already hold their
   // target, so their flush only burns time.
   // an apb write to file 1 in the cycle of an
   // event edge wins, so software can preset
   // the count
   // apb file writes win over execution, but
   // pass only while run is low
   // execute: one instruction per four phases, taken skips/jumps add a flush
   logic do_exec;
   assign do_exec = exec_now && (state_r == core_pkg::st_exec);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r    <= core_pkg::PC_RESET;
         w_r     <= 8'h00;
         skip_r  <= 1'b0;
         hop_r   <= 1'b0;
         stack_r <= '{default: 9'h000};
         file_r  <= '{default: 8'h00};
      end else begin
         skip_r <= 1'b0;
         // event counter counts synchronised rising edges
         if (ev_s2_r && !ev_d_r) begin
            file_r[core_pkg::F_COUNTER] <= file_r[core_pkg::F_COUNTER] + 8'h01;
         end
         if (!run_r && wr_en && pready && pa[11:7] == core_pkg::A_FILE_BASE[11:7]) begin
            file_r[pa[6:2]] <= pwdata[7:0];
         end else if (exec_now && state_r == core_pkg::st_flush) begin
            if (hop_r) begin
               pc_r <= pc_inc;
            end
         end else if (do_exec) begin
            pc_r  <= pc_inc;
            hop_r <= 1'b0;
            case (insn[11:8])
               // a hit on the pc file is a computed jump
               core_pkg::bit_clear_op, core_pkg::bit_set_op: begin
                  if (fa == core_pkg::F_PC) begin
                     pc_r <= {1'b0, fval} ^ ({1'b0, fval} ^ {1'b0,
                             (insn[8] ? fval | (8'h01 << bi.bitn) : fval & ~(8'h01 << bi.bitn))});
                     skip_r <= 1'b1;
                  end else if (fa != core_pkg::F_INDIRECT) begin
                     file_r[fa][bi.bitn] <= insn[8];
                  end
               end
               // skips read the same view as software
               core_pkg::skip_if_bit_low_op: begin
                  skip_r <= !bit_v;
                  hop_r  <= !bit_v;
               end
               core_pkg::skip_if_bit_high_op: begin
                  skip_r <= bit_v;
                  hop_r  <= bit_v;
               end
               // literal to w, pop the stack into pc
               core_pkg::return_with_literal_op: begin
                  w_r     <= lit;
                  pc_r    <= stack_r[0];
                  stack_r[0] <= stack_r[1];
                  skip_r  <= 1'b1;
               end
               // push the next address, jump in page 0
               core_pkg::call_op: begin
                  stack_r[1] <= stack_r[0];
                  stack_r[0] <= pc_inc;
                  pc_r    <= {1'b0, lit};
                  skip_r  <= 1'b1;
               end
               // bit 8 picks the page
               4'b1010, 4'b1011: begin
                  pc_r   <= {insn[8], lit};
                  skip_r <= 1'b1;
               end
               // only the logic forms touch zero
               4'b1100, 4'b1101, 4'b1110, 4'b1111: begin
                  w_r <= alu;
                  if (insn[11:8] != core_pkg::load_literal_op) begin
                     file_r[core_pkg::F_STATUS][core_pkg::ST_ZERO] <= (alu == 8'h00);
                  end
               end
               default: begin
                  // byte file group not implemented; behaves as no operation
               end
            endcase
         end
      end
   end

   // port_out stays low: lines are pulled or
   // released, never driven high, so wired-and
   // with outside devices is safe. reset leaves
   // every latch 0, pulling all lines low until
   // software writes ones
   // the enable comes from a flop, so a latch
   // write shows one cycle later
   // ports: latch 1 releases the line, 0 pulls it low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_out <= 32'h0000_0000;
         port_oe  <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < 4; i++) begin
            port_out[8*i +: 8] <= 8'h00;
            port_oe[8*i +: 8]  <= ~file_r[5+i];
         end
      end
   end
endmodule : byte_controller_core

// [byte_controller_core_sva.sv]
/*
 byte_controller_core_sva: port-level checker for the controller core.
 assumes a single pclk domain and an apb master that keeps the setup/access order.
*/
`timescale 1ns/1ps
module byte_controller_core_sva (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // i/o lines and event input
   input wire logic [31:0] port_in,
   input wire logic [31:0] port_out,
   input wire logic [31:0] port_oe,
   input wire logic        event_in
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       acc;
   logic       run_r;
   logic       ran_r;
   logic [7:0] oe_exp_r;
   assign acc = psel && penable && pready;
   // shadow of the run bit; file writes are only honoured while halted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
         ran_r <= 1'b0;
      end else if (acc && pwrite && paddr == core_pkg::A_CTRL) begin
         run_r <= pwdata[core_pkg::CTRL_RUN];
         ran_r <= ran_r | pwdata[core_pkg::CTRL_RUN];
      end
   end
   // a low latch bit pulls the line, so the expected enable is inverted data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_exp_r <= 8'h00;
      end else if (acc && pwrite && paddr == core_pkg::A_FILE_BASE + 12'h014) begin
         oe_exp_r <= ~pwdata[7:0];
      end
   end
   property p_ready_after_setup; psel && !penable |=> pready; endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("pready missing after setup");
   property p_ready_in_access; pready |-> psel && penable; endproperty
   a_ready_in_access: assert property (p_ready_in_access)
      else $error("pready outside access phase");
   property p_ready_single; pready |=> !pready; endproperty
   a_ready_single: assert property (p_ready_single)
      else $error("pready held two cycles");
   property p_err_unmapped; acc && !pwrite && paddr inside {[12'h014:12'h07c]} |-> pslverr; endproperty
   a_err_unmapped: assert property (p_err_unmapped)
      else $error("unmapped read without error");
   property p_pointer_top; acc && !pwrite && paddr == core_pkg::A_FILE_BASE + 12'h010 |-> prdata[7:5] == 3'b111;
   endproperty
   a_pointer_top: assert property (p_pointer_top)
      else $error("pointer top bits not one");
   property p_port_latch; acc && pwrite && !run_r && paddr == core_pkg::A_FILE_BASE + 12'h014
      |-> ##[1:2] port_oe[7:0] == oe_exp_r; endproperty
   a_port_latch: assert property (p_port_latch)
      else $error("port enable does not follow latch");
   property p_out_low; port_out == 32'h0000_0000; endproperty
   a_out_low: assert property (p_out_low)
      else $error("port output not low");
   property p_pc_reset; acc && !pwrite && !ran_r && paddr == core_pkg::A_STAT |-> prdata[8:0] == core_pkg::PC_RESET;
   endproperty
   a_pc_reset: assert property (p_pc_reset)
      else $error("pc not at top after reset");
endmodule : byte_controller_core_sva
bind byte_controller_core byte_controller_core_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .event_in(event_in));

// [byte_controller_core_tb_top.sv]
/*
 byte_controller_core_tb_top: directed bench for the controller core.
 assumes the core answers apb in the first access cycle and loads program while halted.
*/
`timescale 1ns/1ps
module byte_controller_core_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, event_in;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, port_in, port_out, port_oe, ext_low;
   int          failures, tests_run, cyc;
   logic [31:0] q;
   logic        e;
   logic [11:0] p_main [8] = '{12'hc5a, 12'hf5a, 12'h743, 12'h509, 12'h5e9, 12'h930, 12'h405, 12'ha17};
   logic [11:0] p_sub  [5] = '{12'hd81, 12'he0f, 12'h643, 12'h5c9, 12'h83c};
   byte_controller_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .event_in(event_in));
   io_line_devices u_lines (.port_oe(port_oe), .ext_low(ext_low), .port_in(port_in));
   task automatic end_sim;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; request held until pready is seen high
   // idle edge at the end keeps back-to-back calls from driving psel twice in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, exp);
   endtask : rd
   task automatic t_files;
      rd(core_pkg::A_STAT, 32'h0000_01ff);
      apb(1'b1, 12'h0a4, 32'h0000_00a5);
      apb(1'b1, 12'h0fc, 32'h0000_003c);
      rd(12'h0a4, 32'h0000_00a5);
      rd(12'h0fc, 32'h0000_003c);
      apb(1'b1, 12'h090, 32'h0000_0009);
      rd(12'h090, 32'h0000_00e9);
      apb(1'b1, 12'h094, 32'h0000_000f);
      @(posedge pclk);
      @(posedge pclk);
      chk({24'h00_0000, port_oe[7:0]}, 32'h0000_00f0);
      chk({24'h00_0000, port_in[7:0]}, 32'h0000_000f);
      // an outside pull on line 0 must show through the synchroniser
      ext_low <= 32'h0000_0001;
      repeat (3) @(posedge pclk);
      rd(12'h094, 32'h0000_000e);
      ext_low <= 32'h0000_0000;
   endtask : t_files
   task automatic t_unmapped;
      apb(1'b0, 12'h040, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
   endtask : t_unmapped
   // edges are spaced well apart so the two-flop synchroniser sees each one
   task automatic t_events;
      apb(1'b1, 12'h084, 32'h0000_0010);
      repeat (3) begin
         event_in <= 1'b1;
         repeat (6) @(posedge pclk);
         event_in <= 1'b0;
         repeat (6) @(posedge pclk);
      end
      rd(12'h084, 32'h0000_0013);
   endtask : t_events
   task automatic t_program;
      int n;
      apb(1'b1, 12'h0a4, 32'h0000_0000);
      apb(1'b1, 12'h094, 32'h0000_00ff);
      apb(1'b1, core_pkg::A_PADDR, 32'h0000_01ff);
      apb(1'b1, core_pkg::A_PDATA, 32'h0000_0a10);
      apb(1'b1, core_pkg::A_PADDR, 32'h0000_0010);
      foreach (p_main[i]) apb(1'b1, core_pkg::A_PDATA, {20'h0_0000, p_main[i]});
      apb(1'b1, core_pkg::A_PADDR, 32'h0000_0030);
      foreach (p_sub[i]) apb(1'b1, core_pkg::A_PDATA, {20'h0_0000, p_sub[i]});
      apb(1'b1, core_pkg::A_CTRL, 32'h0000_0001);
      n = 0;
      q = 32'h0000_0000;
      while (q[8:0] !== 9'h017 && n < 200) begin
         n++;
         apb(1'b0, core_pkg::A_STAT, 32'h0000_0000);
      end
      chk({23'h0, q[8:0]}, 32'h0000_0017);
      apb(1'b1, core_pkg::A_CTRL, 32'h0000_0000);
      rd(12'h0a4, 32'h0000_0080);
      rd(core_pkg::A_WREG, 32'h0000_003c);
      apb(1'b0, 12'h08c, 32'h0000_0000);
      chk({31'h0, q[core_pkg::ST_ZERO]}, 32'h0000_0000);
      chk({31'h0, port_oe[0]}, 32'h0000_0001);
      chk({31'h0, port_in[0]}, 32'h0000_0000);
   endtask : t_program
   // free-running clock at 8 ns
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // hang guard, well above the few hundred cycles the tests need
   initial begin
      for (cyc = 0; cyc < 20000; cyc++) @(posedge pclk);
      failures++;
      end_sim();
   end
   initial begin
      {presetn, psel, penable, pwrite, event_in} = 5'b00000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      ext_low = 32'h0000_0000;
      failures = 0;
      tests_run = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_files();
      t_unmapped();
      t_events();
      t_program();
      end_sim();
   end
endmodule : byte_controller_core_tb_top

// [core_pkg.sv]
/*
 core_pkg: constants and types for the byte controller core.
 assumes a single pclk domain, apb master outside, program store written over apb.
*/
// Summary of operation
// - thirty-two 8-bit file registers on one internal bus
// - files 0 to 8 are operational: counter, status, pc, pointer, ports
// - files 9 to 31 are plain storage without side effects
// - program store holds 512 words of 12 bits, fetched at pc
// - pc advances by one after each instruction
// - writing the pc file register performs a computed jump
// - push-down return stack, top element is the return address register
// - reset sets pc to octal 777 and starts there
// - instruction takes four periods, eight when skipping or changing pc
// - file-select field picks one of 32 file registers
// - destination bit 0 writes working register, 1 writes file; the code runs the byte file opcodes as no-ops
// - one working accumulator, boolean operations with file registers; the code does them with literals only
// - opcodes 0100 and 0101 clear and set a file bit, status untouched
// - opcodes 0110 and 0111 skip when bit clear or set
// - opcode 1000 loads literal into w and pops return address
// - opcode 1001 pushes return address and jumps to literal
// - opcode 101x jumps to literal, x extends the address
// - 1100..1111 move, or, and, xor literal; logic forms update zero
// - event counter counts external events, readable and writable
// - four 8-bit port registers in the operational range
// - jump x bit selects program page 0 or 1
// - status: carry bit 0, nibble carry bit 1, zero bit 2
// - file 0 is indirect through pointer file 4, top three bits read one
package core_pkg;
   localparam int          FILE_N       = 32;
   localparam int          PROG_N       = 512;
   localparam int          STACK_N      = 2;
   localparam logic [4:0]  F_INDIRECT   = 5'h00;
   localparam logic [4:0]  F_COUNTER    = 5'h01;
   localparam logic [4:0]  F_PC         = 5'h02;
   localparam logic [4:0]  F_STATUS     = 5'h03;
   localparam logic [4:0]  F_POINTER    = 5'h04;
   localparam logic [4:0]  F_PORT_A     = 5'h05;
   localparam logic [4:0]  F_PORT_D     = 5'h08;
   localparam int          ST_CARRY     = 0;
   localparam int          ST_NIBBLE    = 1;
   localparam int          ST_ZERO      = 2;
   localparam logic [8:0]  PC_RESET     = 9'h1ff;
   localparam logic [1:0]  PHASE_LAST   = 2'h3;
   // apb map (byte addresses)
   localparam logic [11:0] A_CTRL       = 12'h000;
   localparam logic [11:0] A_STAT       = 12'h004;
   localparam logic [11:0] A_PADDR      = 12'h008;
   localparam logic [11:0] A_PDATA      = 12'h00c;
   localparam logic [11:0] A_WREG       = 12'h010;
   localparam logic [11:0] A_FILE_BASE  = 12'h080;
   localparam int          CTRL_RUN     = 0;
   localparam int          CTRL_EVENT   = 1;
   typedef enum logic [3:0] {
      bit_clear_op          = 4'b0100,
      bit_set_op            = 4'b0101,
      skip_if_bit_low_op    = 4'b0110,
      skip_if_bit_high_op   = 4'b0111,
      return_with_literal_op= 4'b1000,
      call_op               = 4'b1001,
      load_literal_op       = 4'b1100,
      or_literal_op         = 4'b1101,
      and_literal_op        = 4'b1110,
      xor_literal_op        = 4'b1111
   } opcode_e;
   typedef enum logic [1:0] {
      st_halt    = 2'b00,
      st_exec    = 2'b01,
      st_flush   = 2'b10
   } state_e;
   typedef struct packed {
      logic [3:0] op;
      logic [2:0] bitn;
      logic [4:0] file;
   } bit_insn_s;
endpackage : core_pkg

// [io_line_devices.sv]
/*
 io_line_devices: open-collector devices on the general i/o lines.
 assumes each line has a pull-up, so a released line reads high.
*/
`timescale 1ns/1ps
module io_line_devices (
   // core pull-down enables
   input wire logic [31:0] port_oe,
   // external open-collector pulls
   input wire logic [31:0] ext_low,
   // resolved line levels
   output logic     [31:0] port_in
);
   // wired-and: any party pulling wins, otherwise the pull-up holds high
   assign port_in = ~(port_oe | ext_low);
endmodule : io_line_devices
